// ### logic/vgagp_pkg.sv
// package: port map, field positions, reset values and states of the block
package vgagp_pkg;
  // host i/o port addresses
  localparam logic [15:0] port_input_status_zero = 16'h03C2;
  localparam logic [15:0] port_sleep_control = 16'h03C3;
  localparam logic [15:0] port_pixel_mask = 16'h03C6;
  localparam logic [15:0] port_read_index = 16'h03C7;
  localparam logic [15:0] port_write_index = 16'h03C8;
  localparam logic [15:0] port_palette_data = 16'h03C9;
  localparam logic [15:0] port_feature_read = 16'h03CA;
  localparam logic [15:0] port_status_mono = 16'h03BA;
  localparam logic [15:0] port_status_colour = 16'h03DA;
  localparam logic [15:0] port_alt_sleep = 16'h46E8;
  // field positions
  localparam int feature_vsync_bit = 3;
  localparam int isz_irq_bit = 7;
  localparam int isz_sense_bit = 4;
  localparam int st_retrace_bit = 3;
  localparam int st_blank_bit = 0;
  localparam int st_diag_lo = 4;
  localparam int sleep_ctl_bit = 0;
  localparam int sleep_rb_bit = 1;
  // reset values
  localparam logic [7:0] rst_pixel_mask = 8'h00;
  localparam logic [7:0] rst_index = 8'h00;
  localparam logic [7:0] rst_feature = 8'h00;
  localparam logic [7:0] rst_sleep = 8'h03;
  localparam logic [2:0] rst_comp = 3'h1;
  localparam logic [1:0] dac_state_write = 2'h0;
  localparam logic [1:0] dac_state_read = 2'h3;
  // colour component counter, one-hot
  typedef enum logic [2:0] {
    vgagp_red = 3'b001,
    vgagp_green = 3'b010,
    vgagp_blue = 3'b100
  } vgagp_comp_type;
endpackage : vgagp_pkg

// ### logic/vgagp_sync2.sv
// two-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module vgagp_sync2 #(
  parameter int width = 1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // level in and out
  input wire logic [width-1:0] din,
  output logic [width-1:0] dout
);
  logic [width-1:0] stage1;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      stage1 <= '0;
      dout <= '0;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule : vgagp_sync2
`default_nettype wire

// ### logic/vgagp_regs.sv
// general status, sleep and palette port registers of the display core
`timescale 1ns/1ps
`default_nettype none
//Contract
// - feature bit3 ors vsync with vertical enable
// - feature written at 3BA/3DA, read 3CA
// - status zero bit7 shows vertical irq pending
// - bit4 shows sense switch picked by clksel
// - status bit3 shows vertical retrace
// - status bit0 low only while displaying
// - diag bits pick colour plane pair
// - overlay input may replace diag bits
// - sleep bit1 mirrors sleep bit0
// - sleep zero gates all but sleep port
// - strap selects 46E8 sleep port instead
// - low sleep pin forces sleep mode
// - zero mask bits ignore pixel bits
// - mask port also reaches hidden dac path
// - read index loaded, steps per three reads
// - dac state reads 00 write, 11 read
// - reset clears mask and both indices
// - write index steps after third write
// - entry written after third component
// - reads supply indexed entry components
// - status at 3BA mono, 3DA colour
module vgagp_regs (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // host i/o port, one-cycle strobes
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_rvalid,
  // configuration from other blocks
  input wire logic colour_mode,
  input wire logic [1:0] clock_select,
  input wire logic [1:0] attribute_diag_select,
  input wire logic overlay_input_en,
  input wire logic sleep_select_strap,
  input wire logic sleep_n,
  // display status in
  input wire logic vsync_in,
  input wire logic vert_display_en,
  input wire logic vert_irq_pending,
  input wire logic vert_retrace,
  input wire logic blanking,
  input wire logic [3:0] dac_sense,
  input wire logic [7:0] colour_plane_outputs,
  input wire logic [7:0] overlay_connector_data,
  input wire logic [7:0] pixel_in,
  // display side out
  output logic vsync_out,
  output logic sleep_active,
  output logic [7:0] lut_pixel,
  // colour lookup table port
  output logic lut_we,
  output logic [7:0] lut_waddr,
  output logic [23:0] lut_wdata,
  output logic [7:0] lut_raddr,
  input wire logic [23:0] lut_rdata,
  // hidden dac register path
  output logic hidden_dac_sel
);
  logic [2:0] status_sync;
  logic [7:0] feature;
  logic [7:0] next_feature;
  logic [7:0] sleep_reg;
  logic [7:0] next_sleep_reg;
  logic [7:0] pixel_mask;
  logic [7:0] next_pixel_mask;
  logic [7:0] read_index;
  logic [7:0] next_read_index;
  logic [7:0] write_index;
  logic [7:0] next_write_index;
  logic [1:0] dac_state;
  logic [1:0] next_dac_state;
  vgagp_pkg::vgagp_comp_type comp;
  vgagp_pkg::vgagp_comp_type next_comp;
  logic [15:0] red_green;
  logic [15:0] next_red_green;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic rvalid;
  logic next_rvalid;
  logic next_lut_we;
  logic [23:0] next_lut_wdata;
  logic [7:0] next_lut_waddr;
  logic next_vsync;
  logic next_sleep_active;
  logic [7:0] next_lut_pixel;
  logic next_hidden;
  logic [15:0] status_port;
  logic [15:0] sleep_port;
  logic asleep;
  logic wr_ok;
  logic rd_ok;
  logic [1:0] diag;
  logic [7:0] status_one;
  logic [7:0] status_zero;

  // async status crosses from the pixel clock domain
  vgagp_sync2 #(.width(3)) u_sync (
    .mclk(mclk),
    .rstn(rstn),
    .din({vert_irq_pending, vert_retrace, blanking}),
    .dout(status_sync)
  );

  always_comb begin
    status_port = colour_mode ? vgagp_pkg::port_status_colour
                              : vgagp_pkg::port_status_mono;
    sleep_port = sleep_select_strap ? vgagp_pkg::port_alt_sleep
                                    : vgagp_pkg::port_sleep_control;
    // a low hardware pin overrides the register setting
    asleep = !sleep_reg[vgagp_pkg::sleep_ctl_bit] || !sleep_n;
    // the sleep port stays live so software can wake the chip
    wr_ok = io_wr && (!asleep || io_addr == sleep_port);
    rd_ok = io_rd && (!asleep || io_addr == sleep_port);

    case (attribute_diag_select)
      2'h0: diag = {colour_plane_outputs[2], colour_plane_outputs[0]};
      2'h1: diag = {colour_plane_outputs[3], colour_plane_outputs[1]};
      2'h2: diag = {colour_plane_outputs[5], colour_plane_outputs[4]};
      default: diag = {colour_plane_outputs[7], colour_plane_outputs[6]};
    endcase
    // debug view of the overlay connector, low pair only
    if (overlay_input_en) begin
      diag = overlay_connector_data[1:0];
    end

    status_one = 8'h00;
    status_one[vgagp_pkg::st_diag_lo +: 2] = diag;
    status_one[vgagp_pkg::st_retrace_bit] = status_sync[1];
    status_one[vgagp_pkg::st_blank_bit] = status_sync[0];

    status_zero = 8'h00;
    status_zero[vgagp_pkg::isz_irq_bit] = status_sync[2];
    status_zero[vgagp_pkg::isz_sense_bit] = dac_sense[clock_select];
  end

  always_comb begin
    next_feature = feature;
    next_sleep_reg = sleep_reg;
    next_pixel_mask = pixel_mask;
    next_read_index = read_index;
    next_write_index = write_index;
    next_dac_state = dac_state;
    next_comp = comp;
    next_red_green = red_green;
    next_rdata = rdata;
    next_rvalid = 1'b0;
    next_lut_we = 1'b0;
    next_lut_wdata = lut_wdata;
    next_lut_waddr = lut_waddr;
    next_hidden = 1'b0;

    // a write and a read in one cycle: the write wins, the read is lost
    if (wr_ok) begin
      if (io_addr == status_port) begin
        next_feature = io_wdata;
      end else if (io_addr == sleep_port) begin
        next_sleep_reg[vgagp_pkg::sleep_ctl_bit] =
          io_wdata[vgagp_pkg::sleep_ctl_bit];
      end else if (io_addr == vgagp_pkg::port_pixel_mask) begin
        next_pixel_mask = io_wdata;
        next_hidden = 1'b1;
      end else if (io_addr == vgagp_pkg::port_read_index) begin
        next_read_index = io_wdata;
        next_dac_state = vgagp_pkg::dac_state_read;
        next_comp = vgagp_pkg::vgagp_red;
      end else if (io_addr == vgagp_pkg::port_write_index) begin
        next_write_index = io_wdata;
        next_dac_state = vgagp_pkg::dac_state_write;
        next_comp = vgagp_pkg::vgagp_red;
      end else if (io_addr == vgagp_pkg::port_palette_data) begin
        case (comp)
          vgagp_pkg::vgagp_red: begin
            next_red_green[15:8] = io_wdata;
            next_comp = vgagp_pkg::vgagp_green;
          end
          vgagp_pkg::vgagp_green: begin
            next_red_green[7:0] = io_wdata;
            next_comp = vgagp_pkg::vgagp_blue;
          end
          vgagp_pkg::vgagp_blue: begin
            // whole entry lands at once, no torn colour on screen
            next_lut_we = 1'b1;
            next_lut_wdata = {red_green, io_wdata};
            next_lut_waddr = write_index;
            next_write_index = write_index + 8'h01;
            next_comp = vgagp_pkg::vgagp_red;
          end
          default: next_comp = vgagp_pkg::vgagp_red;
        endcase
      end
    end else if (rd_ok) begin
      next_rvalid = 1'b1;
      // unmapped reads still answer, with zero, except while asleep, when only the sleep port answers
      next_rdata = 8'h00;
      if (io_addr == status_port) begin
        next_rdata = status_one;
      end else if (io_addr == vgagp_pkg::port_input_status_zero) begin
        next_rdata = status_zero;
      end else if (io_addr == vgagp_pkg::port_feature_read) begin
        next_rdata = feature;
      end else if (io_addr == sleep_port) begin
        next_rdata = sleep_reg;
      end else if (io_addr == vgagp_pkg::port_pixel_mask) begin
        next_rdata = pixel_mask;
        next_hidden = 1'b1;
      end else if (io_addr == vgagp_pkg::port_read_index) begin
        next_rdata = {6'h00, dac_state};
      end else if (io_addr == vgagp_pkg::port_write_index) begin
        next_rdata = write_index;
      end else if (io_addr == vgagp_pkg::port_palette_data) begin
        case (comp)
          vgagp_pkg::vgagp_red: begin
            next_rdata = lut_rdata[23:16];
            next_comp = vgagp_pkg::vgagp_green;
          end
          vgagp_pkg::vgagp_green: begin
            next_rdata = lut_rdata[15:8];
            next_comp = vgagp_pkg::vgagp_blue;
          end
          vgagp_pkg::vgagp_blue: begin
            next_rdata = lut_rdata[7:0];
            next_read_index = read_index + 8'h01;
            next_comp = vgagp_pkg::vgagp_red;
          end
          default: next_comp = vgagp_pkg::vgagp_red;
        endcase
      end
    end

    // readback bit always follows the control bit
    next_sleep_reg[vgagp_pkg::sleep_rb_bit] =
      next_sleep_reg[vgagp_pkg::sleep_ctl_bit];

    next_vsync = vsync_in;
    if (feature[vgagp_pkg::feature_vsync_bit]) begin
      next_vsync = vsync_in | vert_display_en;
    end
    // vsync_out goes low while asleep
    if (asleep) begin
      next_vsync = 1'b0;
    end

    next_sleep_active = asleep;
    next_lut_pixel = pixel_in & pixel_mask;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      feature <= vgagp_pkg::rst_feature;
      sleep_reg <= vgagp_pkg::rst_sleep;
      pixel_mask <= vgagp_pkg::rst_pixel_mask;
      read_index <= vgagp_pkg::rst_index;
      write_index <= vgagp_pkg::rst_index;
      dac_state <= vgagp_pkg::dac_state_write;
      comp <= vgagp_pkg::vgagp_red;
      red_green <= 16'h0000;
      rdata <= 8'h00;
      rvalid <= 1'b0;
      lut_we <= 1'b0;
      lut_wdata <= 24'h000000;
      lut_waddr <= 8'h00;
      vsync_out <= 1'b0;
      sleep_active <= 1'b0;
      lut_pixel <= 8'h00;
      hidden_dac_sel <= 1'b0;
    end else begin
      feature <= next_feature;
      sleep_reg <= next_sleep_reg;
      pixel_mask <= next_pixel_mask;
      read_index <= next_read_index;
      write_index <= next_write_index;
      dac_state <= next_dac_state;
      comp <= next_comp;
      red_green <= next_red_green;
      rdata <= next_rdata;
      rvalid <= next_rvalid;
      lut_we <= next_lut_we;
      lut_wdata <= next_lut_wdata;
      lut_waddr <= next_lut_waddr;
      vsync_out <= next_vsync;
      sleep_active <= next_sleep_active;
      lut_pixel <= next_lut_pixel;
      hidden_dac_sel <= next_hidden;
    end
  end

  assign io_rdata = rdata;
  assign io_rvalid = rvalid;

  // read address is the index register itself, a flop
  assign lut_raddr = read_index;
endmodule : vgagp_regs
`default_nettype wire

// ### tb/vgagp_regs_props.sv
// checker of the host port, palette and sleep behaviour at the block's pins
`timescale 1ns/1ps
`default_nettype none
module vgagp_regs_props (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // host port
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic io_rvalid,
  // sleep and display
  input wire logic sleep_n,
  input wire logic sleep_active,
  input wire logic vsync_in,
  input wire logic vert_display_en,
  input wire logic vsync_out,
  input wire logic [7:0] pixel_in,
  input wire logic [7:0] lut_pixel,
  // lookup table port
  input wire logic lut_we,
  input wire logic [7:0] lut_raddr,
  input wire logic hidden_dac_sel
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // a sleep write shows on sleep_active one cycle late, so the cycle
  // right after any write is left out of the awake window
  logic prev_wr;
  logic awake;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prev_wr <= 1'b0;
    end else begin
      prev_wr <= io_wr;
    end
  end
  assign awake = sleep_n && !sleep_active && !prev_wr;
  chk_read_answered: assert property (
    io_rd && !io_wr && awake |=> io_rvalid)
    else $error("accepted read gave no answer");
  chk_answer_cause: assert property (io_rvalid |-> $past(io_rd))
    else $error("answer without a read");
  chk_mask_bits: assert property (
    (lut_pixel & ~$past(pixel_in)) == 8'h00)
    else $error("pixel bit passed that was not set");
  chk_vsync_cause: assert property (
    vsync_out |-> $past(vsync_in || vert_display_en))
    else $error("sync out high without cause");
  chk_entry_once: assert property (lut_we |=> !lut_we [*2])
    else $error("table written before three components");
  chk_entry_cause: assert property (
    lut_we |-> $past(io_wr && io_addr == vgagp_pkg::port_palette_data))
    else $error("table write not after a data port write");
  chk_read_index: assert property (
    io_wr && io_addr == vgagp_pkg::port_read_index && awake
    |=> lut_raddr == $past(io_wdata))
    else $error("read index not loaded");
  chk_sleep_pin: assert property (!sleep_n [*3] |-> sleep_active)
    else $error("sleep pin low but block awake");
  chk_hidden_path: assert property (
    (io_wr || io_rd) && io_addr == vgagp_pkg::port_pixel_mask && awake
    |=> hidden_dac_sel)
    else $error("mask port access did not select hidden path");
  chk_sleep_quiet: assert property (sleep_active |-> !vsync_out)
    else $error("sync out driven while asleep");
endmodule : vgagp_regs_props
`default_nettype wire

// ### tb/vgagp_lut_model.sv
// colour lookup table storage seen across the block's table port
`timescale 1ns/1ps
`default_nettype none
module vgagp_lut_model (
  // clock
  input wire logic mclk,
  // table port
  input wire logic lut_we,
  input wire logic [7:0] lut_waddr,
  input wire logic [23:0] lut_wdata,
  input wire logic [7:0] lut_raddr,
  output logic [23:0] lut_rdata
);
  logic [23:0] mem [256];
  // filled with a pattern so a missed write reads as zero only at entry A5
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = {3{8'(i)}} ^ 24'hA5A5A5;
    end
  end
  always @(posedge mclk) begin
    if (lut_we) begin
      mem[lut_waddr] <= lut_wdata;
    end
  end
  assign lut_rdata = mem[lut_raddr];
endmodule : vgagp_lut_model
`default_nettype wire

// ### tb/vgagp_regs_bench.sv
// self-checking bench of the status, sleep and palette port registers
`timescale 1ns/1ps
`default_nettype none
module vgagp_regs_bench;
  logic mclk = 1'b0, rstn = 1'b0, io_wr = 1'b0, io_rd = 1'b0;
  logic colour_mode = 1'b0, overlay_input_en = 1'b0, sleep_n = 1'b1;
  logic sleep_select_strap = 1'b0, vsync_in = 1'b0, vert_display_en = 1'b0;
  logic vert_irq_pending = 1'b0, vert_retrace = 1'b0, blanking = 1'b0;
  logic [15:0] io_addr = 16'h0000;
  logic [7:0] io_wdata = 8'h00, pixel_in = 8'h00;
  logic [1:0] clock_select = 2'h0, attribute_diag_select = 2'h0;
  logic [3:0] dac_sense = 4'h4;
  logic [7:0] colour_plane_outputs = 8'hC6, overlay_connector_data = 8'h02;
  logic [7:0] io_rdata, lut_pixel, lut_waddr, lut_raddr;
  logic io_rvalid, vsync_out, sleep_active, lut_we, hidden_dac_sel;
  logic [23:0] lut_wdata, lut_rdata;
  logic [1:0] pairs [4] = '{2'h2, 2'h1, 2'h0, 2'h3};
  int n_mismatch = 0, n_tests = 0, cycles = 0;
  vgagp_regs vgagp_regs_i (.*);
  vgagp_lut_model vgagp_lut_model_i (.*);
  always #2.5 mclk = ~mclk;
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    io_wr <= 1'b1;
    io_addr <= a;
    io_wdata <= d;
    @(posedge mclk);
    io_wr <= 1'b0;
  endtask : wr
  // a zero mask means the read must be refused
  task automatic rx(input logic [15:0] a, input logic [7:0] e, m);
    @(posedge mclk);
    io_rd <= 1'b1;
    io_addr <= a;
    @(posedge mclk);
    io_rd <= 1'b0;
    #1;
    check(io_rvalid, m != 8'h00);
    check(io_rdata & m, e);
    // hand back on an edge so the caller's next stimulus lands on one
    @(posedge mclk);
  endtask : rx
  task automatic results();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch++;
      results();
    end
  end
  initial begin
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    rx(16'h03C6, 8'h00, 8'hFF);
    rx(16'h03C7, 8'h00, 8'h03);
    rx(16'h03C8, 8'h00, 8'hFF);
    rx(16'h03C3, 8'h03, 8'h03);
    wr(16'h03BA, 8'h08);
    vert_display_en <= 1'b1;
    rx(16'h03CA, 8'h08, 8'h08);
    check(vsync_out, 1'b1);
    wr(16'h03DA, 8'h00);
    rx(16'h03CA, 8'h08, 8'h08);
    colour_mode <= 1'b1;
    wr(16'h03DA, 8'h00);
    rx(16'h03CA, 8'h00, 8'h08);
    check(vsync_out, 1'b0);
    vert_retrace <= 1'b1;
    blanking <= 1'b1;
    vert_irq_pending <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      attribute_diag_select <= 2'(s);
      repeat (3) @(posedge mclk);
      rx(16'h03DA, {2'b00, pairs[s], 4'b1001}, 8'h39);
      clock_select <= 2'(s);
      rx(16'h03C2, {1'b1, 2'b00, dac_sense[s], 4'h0}, 8'h90);
    end
    vert_retrace <= 1'b0;
    blanking <= 1'b0;
    vert_irq_pending <= 1'b0;
    repeat (3) @(posedge mclk);
    rx(16'h03DA, 8'h30, 8'h39);
    rx(16'h03C2, 8'h00, 8'h80);
    overlay_input_en <= 1'b1;
    rx(16'h03DA, 8'h20, 8'h30);
    wr(16'h03C6, 8'h5A);
    pixel_in <= 8'hF0;
    rx(16'h03C6, 8'h5A, 8'hFF);
    check(lut_pixel, 8'h50);
    wr(16'h03C8, 8'h10);
    wr(16'h03C9, 8'h11);
    wr(16'h03C9, 8'h22);
    wr(16'h03C9, 8'h33);
    rx(16'h03C8, 8'h11, 8'hFF);
    check(vgagp_lut_model_i.mem[8'h10], 24'h112233);
    wr(16'h03C8, 8'h20);
    wr(16'h03C9, 8'h99);
    wr(16'h03C8, 8'h20);
    wr(16'h03C9, 8'h44);
    wr(16'h03C9, 8'h55);
    wr(16'h03C9, 8'h66);
    rx(16'h03C8, 8'h21, 8'hFF);
    check(vgagp_lut_model_i.mem[8'h20], 24'h445566);
    rx(16'h03C7, 8'h00, 8'h03);
    wr(16'h03C7, 8'h10);
    rx(16'h03C7, 8'h03, 8'h03);
    rx(16'h03C9, 8'h11, 8'hFF);
    rx(16'h03C9, 8'h22, 8'hFF);
    rx(16'h03C9, 8'h33, 8'hFF);
    check(lut_raddr, 8'h11);
    wr(16'h03C3, 8'h00);
    rx(16'h03C3, 8'h00, 8'h03);
    rx(16'h03C6, 8'h00, 8'h00);
    wr(16'h03C3, 8'h01);
    rx(16'h03C6, 8'h5A, 8'hFF);
    sleep_select_strap <= 1'b1;
    wr(16'h03C3, 8'h00);
    rx(16'h03C6, 8'h5A, 8'hFF);
    wr(16'h46E8, 8'h00);
    rx(16'h03C6, 8'h00, 8'h00);
    wr(16'h46E8, 8'h01);
    sleep_n <= 1'b0;
    rx(16'h03C6, 8'h00, 8'h00);
    check(sleep_active, 1'b1);
    sleep_n <= 1'b1;
    rx(16'h03C6, 8'h5A, 8'hFF);
    results();
  end
endmodule : vgagp_regs_bench
bind vgagp_regs vgagp_regs_props vgagp_regs_props_i (
  .mclk(mclk),
  .rstn(rstn),
  .io_addr(io_addr),
  .io_wr(io_wr),
  .io_rd(io_rd),
  .io_wdata(io_wdata),
  .io_rvalid(io_rvalid),
  .sleep_n(sleep_n),
  .sleep_active(sleep_active),
  .vsync_in(vsync_in),
  .vert_display_en(vert_display_en),
  .vsync_out(vsync_out),
  .pixel_in(pixel_in),
  .lut_pixel(lut_pixel),
  .lut_we(lut_we),
  .lut_raddr(lut_raddr),
  .hidden_dac_sel(hidden_dac_sel)
);
`default_nettype wire
